// >>> src/par_pkg.sv
// Constants, register map and types for the private address resolver.
// Assumes one 100 MHz clock and word-aligned RAM pointers from firmware.
//
// Summary of operation
// R1: A task fires on a write of one or an input pulse.
// R2: Events set their register; only a firmware zero write clears it.
// R3: Events still pulse while their register holds one.
// R4: One interrupt output, high on any enabled pending event.
// R5: Enable set/clear: ones set or clear, zeros ignored, reads give mask.
// R6: Interrupt may stay high four cycles after clear or disable.
// R7: Firmware reads a register after clearing, before leaving its handler.
// R8: Firmware configures registers, then enables the block.
// R9: Enable 3 enables, 0 disables; disabled tasks do nothing.
// R10: Start fetches the six-byte address at the address pointer.
// R11: The address is exactly six bytes read from memory.
// R12: Keys lie 16 bytes apart from the table pointer, tried from zero.
// R13: Only key count keys are tried.
// R14: Key count accepts 1 to 16 and resets to one.
// R15: First matching key raises resolved and ends the search.
// R16: No match among the count raises not-resolved.
// R17: End follows every finished resolution.
// R18: Status holds the index of the last resolving key.
// R19: Memory accesses finish before end or result events.
// R20: Address type bits are never examined or filtered.
// R21: The scratch area holds working data during a resolution.
// R22: Firmware keeps all three pointers in data RAM.
// R23: Start may follow the first six packet bytes landing in RAM.
// R24: Stop aborts a resolution and returns to idle.
package par_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_START_TASK = 12'h000,
        OFS_STOP_TASK = 12'h008,
        OFS_DONE_EVENT = 12'h100,
        OFS_MATCH_EVENT = 12'h104,
        OFS_NOMATCH_EVENT = 12'h108,
        OFS_IRQ_ENABLE_SET = 12'h304,
        OFS_IRQ_ENABLE_CLEAR = 12'h308,
        OFS_LAST_KEY_INDEX = 12'h400,
        OFS_RESOLVER_ENABLE = 12'h500,
        OFS_KEY_COUNT = 12'h504,
        OFS_KEY_TABLE_POINTER = 12'h508,
        OFS_ADDRESS_POINTER = 12'h510,
        OFS_SCRATCH_POINTER = 12'h514;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int IRQ_BIT_DONE = 0, IRQ_BIT_MATCH = 1, IRQ_BIT_NOMATCH = 2;
    localparam logic [1:0] ENABLE_ON = 2'h3, ENABLE_RESET = 2'h0;
    localparam logic [4:0] KEY_COUNT_RESET = 5'h01, KEY_COUNT_MAX = 5'h10;
    localparam logic [31:0] POINTER_RESET = 32'h0000_0000;
    localparam logic [3:0] KEY_INDEX_RESET = 4'h0;
    localparam logic [1:0] KEY_WORDS_LAST = 2'h3, ADDR_WORDS_LAST = 2'h1;
    localparam int KEY_STRIDE_SHIFT = 4;

    typedef enum logic [2:0] {
        PAR_IDLE,
        PAR_FETCH_ADDR,
        PAR_FETCH_KEY,
        PAR_CIPHER,
        PAR_SCRATCH
    } par_state_t;

endpackage

// >>> src/par_resolver.sv
// Private address resolver: register slave, RAM fetch master, search engine.
// Assumes an external block cipher unit answering with a one-cycle ack and
// a RAM master port that honours Avalon-MM waitrequest.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module par_resolver (
    input wire logic clk_in,
    input wire logic rst_in,
    // Register slave
    input wire logic [11:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Task inputs from the event-task interconnect
    input wire logic start_task_in,
    input wire logic stop_task_in,
    // Event pulses toward the interconnect, and the interrupt output
    output logic done_event_out,
    output logic match_event_out,
    output logic nomatch_event_out,
    output logic irq_out,
    // RAM master
    output logic dma_read_out,
    output logic dma_write_out,
    output logic [31:0] dma_address_out,
    output logic [31:0] dma_writedata_out,
    input wire logic [31:0] dma_readdata_in,
    input wire logic dma_waitrequest_in,
    // Block cipher unit
    output logic cipher_req_out,
    output logic [127:0] cipher_key_out,
    output logic [127:0] cipher_data_out,
    input wire logic cipher_ack_in,
    input wire logic [127:0] cipher_result_in
);
    import par_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    par_state_t state_q;
    logic ack_q, wr_take, start_req, stop_req, abort_q, dma_done, irq_q;
    logic done_pulse_q, match_pulse_q, nomatch_pulse_q, last_key;
    logic [31:0] rdata_q, rd_mux, key_addr;
    logic [31:0] key_ptr_q, addr_ptr_q, scratch_ptr_q;
    logic [2:0] event_q, irq_mask_q, ev_pulse;
    logic [1:0] enable_q, word_q;
    logic [4:0] key_count_q, key_idx_q;
    logic [3:0] last_index_q;
    logic [47:0] addr_q;
    logic [127:0] key_q;
    logic [23:0] hash_q;

    // ------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------
    // Every access waits exactly one cycle, so read data can be registered.
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign wr_take = avs_write_in & ack_q;
    assign avs_readdata_out = rdata_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address_in == OFS_DONE_EVENT) begin
            rd_mux = 32'(event_q[IRQ_BIT_DONE]);
        end else if (avs_address_in == OFS_MATCH_EVENT) begin
            rd_mux = 32'(event_q[IRQ_BIT_MATCH]);
        end else if (avs_address_in == OFS_NOMATCH_EVENT) begin
            rd_mux = 32'(event_q[IRQ_BIT_NOMATCH]);
        end else if (avs_address_in == OFS_IRQ_ENABLE_SET ||
                     avs_address_in == OFS_IRQ_ENABLE_CLEAR) begin
            rd_mux = 32'(irq_mask_q); // R5
        end else if (avs_address_in == OFS_LAST_KEY_INDEX) begin
            rd_mux = 32'(last_index_q); // R18
        end else if (avs_address_in == OFS_RESOLVER_ENABLE) begin
            rd_mux = 32'(enable_q);
        end else if (avs_address_in == OFS_KEY_COUNT) begin
            rd_mux = 32'(key_count_q);
        end else if (avs_address_in == OFS_KEY_TABLE_POINTER) begin
            rd_mux = key_ptr_q;
        end else if (avs_address_in == OFS_ADDRESS_POINTER) begin
            rd_mux = addr_ptr_q;
        end else if (avs_address_in == OFS_SCRATCH_POINTER) begin
            rd_mux = scratch_ptr_q;
        end
    end

    // Task registers and unmapped offsets read as zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_in & ~ack_q) begin
            rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            enable_q <= ENABLE_RESET;
            key_count_q <= KEY_COUNT_RESET; // R14
            key_ptr_q <= POINTER_RESET;
            addr_ptr_q <= POINTER_RESET;
            scratch_ptr_q <= POINTER_RESET;
        end else if (wr_take) begin
            if (avs_address_in == OFS_RESOLVER_ENABLE) begin
                enable_q <= avs_writedata_in[1:0];
            end else if (avs_address_in == OFS_KEY_COUNT) begin
                // Out-of-range counts are dropped: no empty or long search
                if (avs_writedata_in != 32'h0000_0000 &&
                    avs_writedata_in <= 32'(KEY_COUNT_MAX)) begin
                    key_count_q <= avs_writedata_in[4:0]; // R14
                end
            end else if (avs_address_in == OFS_KEY_TABLE_POINTER) begin
                key_ptr_q <= avs_writedata_in;
            end else if (avs_address_in == OFS_ADDRESS_POINTER) begin
                addr_ptr_q <= avs_writedata_in;
            end else if (avs_address_in == OFS_SCRATCH_POINTER) begin
                scratch_ptr_q <= avs_writedata_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    assign start_req = (enable_q == ENABLE_ON) & (start_task_in |
        (wr_take & avs_address_in == OFS_START_TASK &
         avs_writedata_in[0])); // R1 R9
    assign stop_req = (enable_q == ENABLE_ON) & (stop_task_in |
        (wr_take & avs_address_in == OFS_STOP_TASK &
         avs_writedata_in[0])); // R1 R9

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign ev_pulse = {nomatch_pulse_q, match_pulse_q, done_pulse_q};
    assign done_event_out = done_pulse_q; // R3
    assign match_event_out = match_pulse_q; // R3
    assign nomatch_event_out = nomatch_pulse_q; // R3

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            event_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ev_pulse[i]) begin
                    event_q[i] <= 1'b1; // R2
                end else if (wr_take && !avs_writedata_in[0] &&
                             avs_address_in == OFS_DONE_EVENT +
                             12'(4 * i)) begin
                    event_q[i] <= 1'b0; // R2
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_q <= 3'h0;
        end else if (wr_take) begin
            if (avs_address_in == OFS_IRQ_ENABLE_SET) begin
                irq_mask_q <= irq_mask_q | avs_writedata_in[2:0]; // R5
            end else if (avs_address_in == OFS_IRQ_ENABLE_CLEAR) begin
                irq_mask_q <= irq_mask_q & ~avs_writedata_in[2:0]; // R5
            end
        end
    end

    // Registered: drops one cycle after a clear, inside the four allowed
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(event_q & irq_mask_q); // R4 R6
        end
    end
    assign irq_out = irq_q;

    // ------------------------------------------------------------
    // Search engine and RAM master
    // ------------------------------------------------------------
    assign key_addr = key_ptr_q + {24'h00_0000, key_idx_q[3:0], 4'h0} +
        {28'h000_0000, word_q, 2'h0}; // R12
    assign dma_done = (dma_read_out | dma_write_out) & ~dma_waitrequest_in;
    assign last_key = (key_idx_q + 5'h01) == key_count_q; // R13

    // Stop cannot cut a RAM access short without breaking the bus, so it
    // is held in abort_q until the pending word completes.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= PAR_IDLE;
            word_q <= 2'h0;
            key_idx_q <= 5'h00;
            addr_q <= 48'h0000_0000_0000;
            key_q <= 128'h0;
            hash_q <= 24'h00_0000;
            abort_q <= 1'b0;
            dma_read_out <= 1'b0;
            dma_write_out <= 1'b0;
            dma_address_out <= 32'h0000_0000;
            dma_writedata_out <= 32'h0000_0000;
            cipher_req_out <= 1'b0;
            last_index_q <= KEY_INDEX_RESET;
            done_pulse_q <= 1'b0;
            match_pulse_q <= 1'b0;
            nomatch_pulse_q <= 1'b0;
        end else begin
            done_pulse_q <= 1'b0;
            match_pulse_q <= 1'b0;
            nomatch_pulse_q <= 1'b0;
            if (stop_req && state_q != PAR_IDLE) begin
                abort_q <= 1'b1;
            end
            case (state_q)
                PAR_IDLE: begin
                    abort_q <= 1'b0;
                    if (start_req && !stop_req) begin
                        state_q <= PAR_FETCH_ADDR; // R10
                        word_q <= 2'h0;
                        key_idx_q <= 5'h00; // R12
                        dma_read_out <= 1'b1;
                        dma_address_out <= addr_ptr_q; // R10 R23
                    end
                end
                PAR_FETCH_ADDR: begin
                    if (dma_done) begin
                        // Six bytes only: the type bits are kept as read
                        if (word_q == 2'h0) begin
                            addr_q[31:0] <= dma_readdata_in; // R11
                        end else begin
                            addr_q[47:32] <= dma_readdata_in[15:0]; // R11 R20
                        end
                        if (abort_q || stop_req) begin
                            dma_read_out <= 1'b0;
                            state_q <= PAR_IDLE; // R24
                        end else if (word_q == ADDR_WORDS_LAST) begin
                            word_q <= 2'h0;
                            state_q <= PAR_FETCH_KEY;
                            dma_address_out <= key_ptr_q; // R12
                        end else begin
                            word_q <= word_q + 2'h1;
                            dma_address_out <= addr_ptr_q + 32'h0000_0004;
                        end
                    end
                end
                PAR_FETCH_KEY: begin
                    if (dma_done) begin
                        key_q[32 * word_q +: 32] <= dma_readdata_in;
                        if (abort_q || stop_req) begin
                            dma_read_out <= 1'b0;
                            state_q <= PAR_IDLE; // R24
                        end else if (word_q == KEY_WORDS_LAST) begin
                            dma_read_out <= 1'b0;
                            cipher_req_out <= 1'b1;
                            state_q <= PAR_CIPHER;
                        end else begin
                            word_q <= word_q + 2'h1;
                            dma_address_out <= key_addr + 32'h0000_0004;
                        end
                    end
                end
                PAR_CIPHER: begin
                    if (stop_req || abort_q) begin
                        cipher_req_out <= 1'b0;
                        state_q <= PAR_IDLE; // R24
                    end else if (cipher_ack_in) begin
                        cipher_req_out <= 1'b0;
                        hash_q <= cipher_result_in[23:0];
                        dma_write_out <= 1'b1;
                        dma_address_out <= scratch_ptr_q; // R21
                        dma_writedata_out <= {8'h00,
                                              cipher_result_in[23:0]}; // R21
                        state_q <= PAR_SCRATCH;
                    end
                end
                PAR_SCRATCH: begin
                    // Events wait for the scratch write to be accepted
                    if (dma_done) begin
                        dma_write_out <= 1'b0;
                        word_q <= 2'h0;
                        if (abort_q || stop_req) begin
                            state_q <= PAR_IDLE; // R24
                        end else if (hash_q == addr_q[23:0]) begin
                            last_index_q <= key_idx_q[3:0]; // R18
                            match_pulse_q <= 1'b1; // R15 R19
                            done_pulse_q <= 1'b1; // R17
                            state_q <= PAR_IDLE; // R15
                        end else if (last_key) begin
                            nomatch_pulse_q <= 1'b1; // R16 R19
                            done_pulse_q <= 1'b1; // R17
                            state_q <= PAR_IDLE;
                        end else begin
                            key_idx_q <= key_idx_q + 5'h01; // R12
                            dma_read_out <= 1'b1;
                            // Still on word 3, so four on is the next slot
                            dma_address_out <= key_addr + 32'h0000_0004;
                            state_q <= PAR_FETCH_KEY;
                        end
                    end
                end
                default: begin
                    state_q <= PAR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Cipher operands
    // ------------------------------------------------------------
    // Plain text is the random part padded with zeros; only the low 24
    // result bits are compared against the hash part.
    assign cipher_key_out = key_q;
    assign cipher_data_out = {104'h0, addr_q[47:24]}; // R20

endmodule

`default_nettype wire

// >>> tb/par_resolver_sva.sv
// Assertion checker for the private address resolver top ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module par_resolver_sva
    import par_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [11:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    input wire logic done_event_out,
    input wire logic match_event_out,
    input wire logic nomatch_event_out,
    input wire logic irq_out,
    input wire logic dma_read_out,
    input wire logic dma_write_out,
    input wire logic [31:0] dma_address_out,
    input wire logic dma_waitrequest_in,
    input wire logic cipher_req_out,
    input wire logic cipher_ack_in,
    input wire logic [127:0] cipher_key_out
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    wait_first_a:
        assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
        else $error("no first wait");
    one_wait_a:
        assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
            |=> !avs_waitrequest_out)
        else $error("wait over one cycle");
    match_end_a:
        assert property (match_event_out |-> done_event_out
            && !nomatch_event_out)
        else $error("match without end");
    nomatch_end_a:
        assert property (nomatch_event_out |-> done_event_out)
        else $error("no-match without end");
    done_pulse_a:
        assert property (done_event_out |=> !done_event_out)
        else $error("end pulse too long");
    dma_done_a:
        assert property (done_event_out |-> !dma_read_out && !dma_write_out
            && $past(dma_write_out && !dma_waitrequest_in))
        else $error("end before RAM done");
    dma_hold_a:
        assert property ((dma_read_out || dma_write_out) && dma_waitrequest_in
            |=> (dma_read_out || dma_write_out) && $stable(dma_address_out))
        else $error("RAM request moved");
    cipher_hold_a:
        assert property (cipher_req_out && !cipher_ack_in
            |=> cipher_req_out && $stable(cipher_key_out))
        else $error("cipher request dropped");
    irq_clear_a:
        assert property (avs_write_in && !avs_waitrequest_out
            && avs_address_in == OFS_IRQ_ENABLE_CLEAR
            && avs_writedata_in[2:0] == 3'h7 |-> ##[1:4] !irq_out)
        else $error("interrupt stuck after disable");
endmodule

bind par_resolver par_resolver_sva chk_u (.*);
`default_nettype wire

// >>> tb/par_ram_model.sv
// Far side of the resolver: 1 KB data RAM and a toy block cipher unit.
// Assumes requests change only after a clock edge; slow_in adds stalls.
`timescale 1ns/1ps
`default_nettype none
module par_ram_model (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic wait_out,
    input wire logic req_in,
    input wire logic [127:0] key_in,
    input wire logic [127:0] data_in,
    output logic ack_out,
    output logic [127:0] res_out
);
    // ------------------------------------------------------------
    // Memory and cipher
    // ------------------------------------------------------------
    logic [31:0] mem [0:255];
    logic stall_q = 1'b0;
    logic ack_q = 1'b0;
    logic [31:0] last_q = 32'h0;
    logic go;
    assign wait_out = slow_in & stall_q;
    assign go = (rd_in | wr_in) & ~wait_out;
    // Released data bus shows the inverse so stale values never pass
    assign rdata_out = (rd_in && go) ? mem[addr_in[9:2]] : ~last_q;
    // Toy cipher: xor, so the bench can build a matching key by hand
    assign ack_out = ack_q;
    assign res_out = ack_q ? (key_in ^ data_in) : ~(key_in ^ data_in);
    always @(posedge clk_in) begin
        stall_q <= (rd_in | wr_in) & ~stall_q;
        ack_q <= req_in & ~ack_q;
        if (rd_in && go)
            last_q <= mem[addr_in[9:2]];
        if (wr_in && go)
            mem[addr_in[9:2]] <= wdata_in;
    end
endmodule
`default_nettype wire

// >>> tb/par_resolver_test.sv
// Self-checking bench for the resolver over its register bus and tasks.
// Assumes the RAM model holds address at 0x000, keys at 0x100.
`timescale 1ns/1ps
`default_nettype none
module par_resolver_test;
    import par_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] avs_address_in = 12'h000;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, dma_address_out, dma_writedata_out;
    logic [31:0] dma_readdata_in, q;
    logic avs_waitrequest_out, done_event_out, match_event_out;
    logic nomatch_event_out, irq_out, dma_read_out, dma_write_out;
    logic dma_waitrequest_in, cipher_req_out, cipher_ack_in;
    logic start_task_in = 1'b0, stop_task_in = 1'b0, slow = 1'b0;
    logic [127:0] cipher_key_out, cipher_data_out, cipher_result_in;
    logic [31:0] last_ra = 32'h0;
    logic [11:0] ra [6] = '{OFS_KEY_COUNT, OFS_RESOLVER_ENABLE,
        OFS_LAST_KEY_INDEX, OFS_IRQ_ENABLE_SET, OFS_SCRATCH_POINTER, 12'h00C};
    int n_errors = 0, n_tests = 0, rd_cnt = 0, dn_cnt = 0, n0;
    // ------------------------------------------------------------
    // Clock, instances, RAM traffic monitor
    // ------------------------------------------------------------
    always #5 clk_in = ~clk_in;
    par_resolver dut_u (.*);
    par_ram_model ram_u (.clk_in(clk_in), .slow_in(slow),
        .rd_in(dma_read_out), .wr_in(dma_write_out),
        .addr_in(dma_address_out), .wdata_in(dma_writedata_out),
        .rdata_out(dma_readdata_in), .wait_out(dma_waitrequest_in),
        .req_in(cipher_req_out), .key_in(cipher_key_out),
        .data_in(cipher_data_out), .ack_out(cipher_ack_in),
        .res_out(cipher_result_in));
    always @(posedge clk_in) begin
        if (dma_read_out === 1'b1 && dma_waitrequest_in === 1'b0) begin
            rd_cnt <= rd_cnt + 1;
            last_ra <= dma_address_out;
        end
        if (done_event_out === 1'b1)
            dn_cnt <= dn_cnt + 1;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fail_to();
        n_errors++;
        $display("[ERR] %0t wait limit used up", $time);
        tally_and_finish();
    endtask
    task automatic bus(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        avs_writedata_in <= d;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0) begin
            if (++n > 20)
                fail_to();
            @(posedge clk_in);
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic pulse(input logic stop);
        start_task_in <= ~stop;
        stop_task_in <= stop;
        @(posedge clk_in);
        start_task_in <= 1'b0;
        stop_task_in <= 1'b0;
        @(posedge clk_in);
    endtask
    // Key word0 of slot hit makes the toy cipher match; others cannot
    task automatic keys(input int hit);
        for (int k = 0; k < 16; k++) begin
            ram_u.mem[64 + 4 * k] = (k == hit) ? 32'h00F57755 : k;
            for (int w = 1; w < 4; w++)
                ram_u.mem[64 + 4 * k + w] = 32'hA5A5A5A5;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic run(input logic pin, input logic [31:0] m, reads, last);
        int base, n;
        base = rd_cnt;
        n = 0;
        if (pin)
            pulse(1'b0);
        else
            wr(OFS_START_TASK, 32'h1);
        while (done_event_out !== 1'b1) begin
            if (++n > 3000)
                fail_to();
            @(posedge clk_in);
        end
        chk({31'h0, match_event_out}, m);
        chk({31'h0, nomatch_event_out}, m ^ 32'h1);
        @(posedge clk_in);
        chk(rd_cnt - base, reads);
        chk(last_ra, last);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        // Type bits of byte five enter the hash unfiltered
        ram_u.mem[0] = 32'h44332211;
        ram_u.mem[1] = 32'h0000C655;
        keys(2);
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(q, (i == 0) ? 32'h1 : 32'h0);
        end
        wr(OFS_KEY_COUNT, 32'h0);
        wr(OFS_KEY_COUNT, 32'h11);
        rd(OFS_KEY_COUNT);
        chk(q, 32'h1);
        wr(OFS_KEY_TABLE_POINTER, 32'h100);
        wr(OFS_SCRATCH_POINTER, 32'h200);
        wr(OFS_KEY_COUNT, 32'h4);
        pulse(1'b0);
        repeat (20) @(posedge clk_in);
        chk(rd_cnt, 32'h0);
        wr(OFS_RESOLVER_ENABLE, 32'h3);
        wr(OFS_IRQ_ENABLE_SET, 32'h7);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h2);
        wr(OFS_IRQ_ENABLE_SET, 32'h0);
        rd(OFS_IRQ_ENABLE_CLEAR);
        chk(q, 32'h5);
        run(1'b0, 32'h1, 32'hE, 32'h12C);
        rd(OFS_LAST_KEY_INDEX);
        chk(q, 32'h2);
        chk(ram_u.mem[128], 32'h00332211);
        chk({31'h0, irq_out}, 32'h1);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h7);
        rd(OFS_DONE_EVENT);
        chk(q, 32'h1);
        chk({31'h0, irq_out}, 32'h0);
        wr(OFS_IRQ_ENABLE_SET, 32'h1);
        rd(OFS_MATCH_EVENT);
        chk({31'h0, irq_out}, 32'h1);
        wr(OFS_DONE_EVENT, 32'h0);
        rd(OFS_DONE_EVENT);
        chk(q, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        keys(16);
        slow <= 1'b1;
        run(1'b1, 32'h0, 32'h12, 32'h13C);
        rd(OFS_LAST_KEY_INDEX);
        chk(q, 32'h2);
        keys(0);
        run(1'b1, 32'h1, 32'h6, 32'h10C);
        rd(OFS_LAST_KEY_INDEX);
        chk(q, 32'h0);
        slow <= 1'b0;
        wr(OFS_KEY_COUNT, 32'h10);
        keys(15);
        run(1'b0, 32'h1, 32'h42, 32'h1FC);
        n0 = dn_cnt;
        wr(OFS_START_TASK, 32'h1);
        repeat (6) @(posedge clk_in);
        pulse(1'b1);
        repeat (300) @(posedge clk_in);
        chk(dn_cnt - n0, 32'h0);
        chk({31'h0, dma_read_out}, 32'h0);
        run(1'b1, 32'h1, 32'h42, 32'h1FC);
        tally_and_finish();
    end
endmodule
`default_nettype wire
